// [hw/eag_consts.vh]
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH

// addressing modes, one code each
`define EAG_MODE_REG_DIRECT 4'h0
`define EAG_MODE_REG_IND 4'h1
`define EAG_MODE_DISP16 4'h2
`define EAG_MODE_DISP24 4'h3
`define EAG_MODE_POST_INC 4'h4
`define EAG_MODE_PRE_DEC 4'h5
`define EAG_MODE_ABS8 4'h6
`define EAG_MODE_ABS16 4'h7
`define EAG_MODE_ABS24 4'h8
`define EAG_MODE_IMM 4'h9
`define EAG_MODE_PC_REL8 4'hA
`define EAG_MODE_PC_REL16 4'hB
`define EAG_MODE_MEM_IND 4'hC

// instruction classes
`define EAG_CLS_ARITH 3'h0
`define EAG_CLS_TRANSFER 3'h1
`define EAG_CLS_BIT 3'h2
`define EAG_CLS_BRANCH 3'h3
`define EAG_CLS_JUMP 3'h4
`define EAG_CLS_IMPLICIT 3'h5
`define EAG_CLS_TRAP 3'h6

// operand sizes
`define EAG_SIZE_BYTE 2'h0
`define EAG_SIZE_WORD 2'h1
`define EAG_SIZE_LONG 2'h2

// address widths and fills
`define EAG_INT_AW 24
`define EAG_OUT_AW 16
`define EAG_ABS8_FILL 8'hFF
`define EAG_EXT_TOP 8'h00
`define EAG_VEC_BASE 16'h0000

`endif

// [hw/eag_size_step.v]
`timescale 1ns/1ps
`default_nettype none
`include "eag_consts.vh"

module eag_size_step (
    input wire [1:0] size_i,
    output reg [31:0] step_o
);
    always @* begin
        case (size_i)
            `EAG_SIZE_BYTE: step_o = 32'h00000001;
            `EAG_SIZE_WORD: step_o = 32'h00000002;
            default: step_o = 32'h00000004;
        endcase
    end
endmodule

`default_nettype wire

// [hw/eag_reg_select.v]
`timescale 1ns/1ps
`default_nettype none
`include "eag_consts.vh"

module eag_reg_select (
    input wire [3:0] rsel_i,
    input wire [1:0] size_i,
    input wire [255:0] regs_i,
    output reg [31:0] value_o
);
    reg [31:0] wide;
    always @* begin
        wide = regs_i[rsel_i[2:0]*32 +: 32];
        case (size_i)
            // bit 3 set picks low byte or upper word; clear picks high byte or lower word
            `EAG_SIZE_BYTE: value_o = {24'h000000, rsel_i[3] ? wide[7:0] : wide[15:8]};
            `EAG_SIZE_WORD: value_o = {16'h0000, rsel_i[3] ? wide[31:16] : wide[15:0]};
            default: value_o = wide;
        endcase
    end
endmodule

`default_nettype wire

// [hw/eag_top.v]
// What this block does
// - thirteen addressing modes, per-class subset only
// - 24-bit internal address, 16-bit output
// - 24-bit extension widened, top byte zero
// - arithmetic: register/immediate; transfer: no PC/memory indirect
// - register direct selects byte, word, long
// - indirect uses low 24 register bits
// - displacement added, 16-bit one sign-extended
// - post-increment add_constant_op size step after access
// - pre-decrement subtracts first, address from result
// - 8-bit absolute fills upper bits ones
// - 16-bit absolute sign-extended upper byte
// - 24-bit absolute reaches whole space
// - immediate delivers 8, 16, 32-bit constant
// - bit ops: direct/indirect/absolute, bit number
// - implicit constants; trap 2-bit vector field
// - PC-relative: sign-extended disp plus next PC
// - memory indirect pointer zero-extended 8 bits
// - pointer longword, first byte dropped
// - register fields three or four bits
`timescale 1ns/1ps
`default_nettype none
`include "eag_consts.vh"

module eag_top (
    input wire SYS_CLK_I,
    input wire RESETN_I,
    input wire START_I,
    input wire [2:0] CLASS_I,
    input wire [3:0] MODE_I,
    input wire [1:0] SIZE_I,
    input wire [3:0] RSEL_I,
    input wire [31:0] EXT_I,
    input wire [2:0] BIT_IMM_I,
    input wire [1:0] TRAP_IMM_I,
    input wire [23:0] PC_NEXT_I,
    input wire [255:0] REGS_I,
    input wire BUS_READY_I,
    input wire PTR_VALID_I,
    input wire [31:0] PTR_DATA_I,
    output reg ADDR_VALID_O,
    output reg [15:0] ADDR_O,
    output reg [1:0] ADDR_SIZE_O,
    output reg PTR_REQ_O,
    output reg [15:0] PTR_ADDR_O,
    output reg OPND_VALID_O,
    output reg [31:0] OPND_O,
    output reg [2:0] BIT_NUM_O,
    output reg BRANCH_VALID_O,
    output reg [23:0] BRANCH_O,
    output reg WB_VALID_O,
    output reg [2:0] WB_REG_O,
    output reg [31:0] WB_DATA_O,
    output reg ILLEGAL_O,
    output reg BUSY_O
);
    // ==========================================
    // state machine
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ADDR = 4'h2;
    localparam [3:0] ST_PTR = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [3:0] mode_ff;
    reg [1:0] size_ff;
    reg [2:0] wreg_ff;
    reg [31:0] wdata_ff;
    reg post_ff;

    // ==========================================
    // legal mode per instruction class
    function legal;
        input [2:0] cls;
        input [3:0] mode;
        begin
            case (cls)
                `EAG_CLS_ARITH: legal = (mode == `EAG_MODE_REG_DIRECT) || (mode == `EAG_MODE_IMM);
                `EAG_CLS_TRANSFER: legal = (mode <= `EAG_MODE_IMM);
                `EAG_CLS_BIT: legal = (mode == `EAG_MODE_REG_DIRECT) || (mode == `EAG_MODE_REG_IND)
                    || (mode == `EAG_MODE_ABS8) || (mode == `EAG_MODE_ABS16) || (mode == `EAG_MODE_ABS24);
                `EAG_CLS_BRANCH: legal = (mode == `EAG_MODE_PC_REL8) || (mode == `EAG_MODE_PC_REL16);
                `EAG_CLS_JUMP: legal = (mode == `EAG_MODE_REG_IND) || (mode == `EAG_MODE_ABS24)
                    || (mode == `EAG_MODE_MEM_IND);
                // implicit constant and trap carry no address
                `EAG_CLS_IMPLICIT: legal = (mode == `EAG_MODE_IMM);
                `EAG_CLS_TRAP: legal = (mode == `EAG_MODE_IMM);
                default: legal = 1'b0;
            endcase
        end
    endfunction

    // ==========================================
    // operand paths
    wire [31:0] reg_val;
    wire [31:0] ptr_reg;
    wire [31:0] step;

    eag_reg_select u_sel (
        .rsel_i(RSEL_I),
        .size_i(SIZE_I),
        .regs_i(REGS_I),
        .value_o(reg_val)
    );

    eag_size_step u_step (
        .size_i(SIZE_I),
        .step_o(step)
    );

    assign ptr_reg = REGS_I[RSEL_I[2:0]*32 +: 32];

    // 24-bit extension widened, top byte zero
    wire [31:0] ext24 = {`EAG_EXT_TOP, EXT_I[23:0]};
    wire [31:0] disp16 = {{16{EXT_I[15]}}, EXT_I[15:0]};
    wire [31:0] sum16 = ptr_reg + disp16;
    // sums wrap at 32 bits; top byte dropped later anyway
    wire [31:0] sum24 = ptr_reg + ext24;
    wire [31:0] dec_val = ptr_reg - step;
    wire [31:0] inc_val = ptr_reg + step;
    wire [23:0] rel8 = PC_NEXT_I + {{16{EXT_I[7]}}, EXT_I[7:0]};
    wire [23:0] rel16 = PC_NEXT_I + {{8{EXT_I[15]}}, EXT_I[15:0]};

    // ==========================================
    // address per mode
    reg [23:0] ea;
    reg has_ea;
    always @* begin
        ea = 24'h000000;
        has_ea = 1'b1;
        case (MODE_I)
            `EAG_MODE_REG_IND: ea = ptr_reg[23:0];
            `EAG_MODE_DISP16: ea = sum16[23:0];
            `EAG_MODE_DISP24: ea = sum24[23:0];
            `EAG_MODE_POST_INC: ea = ptr_reg[23:0];
            `EAG_MODE_PRE_DEC: ea = dec_val[23:0];
            `EAG_MODE_ABS8: ea = {`EAG_ABS8_FILL, `EAG_ABS8_FILL, EXT_I[7:0]};
            `EAG_MODE_ABS16: ea = {{8{EXT_I[15]}}, EXT_I[15:0]};
            `EAG_MODE_ABS24: ea = EXT_I[23:0];
            // no memory address: operand or branch only
            default: has_ea = 1'b0;
        endcase
    end

    // ==========================================
    // immediate operand
    // immediate width by size
    reg [31:0] imm_val;
    always @* begin
        case (SIZE_I)
            `EAG_SIZE_BYTE: imm_val = {24'h000000, EXT_I[7:0]};
            `EAG_SIZE_WORD: imm_val = {16'h0000, EXT_I[15:0]};
            default: imm_val = EXT_I;
        endcase
    end

    // ==========================================
    // request accept and sequencing
    wire take = START_I && state_ff == ST_IDLE;
    wire ok = legal(CLASS_I, MODE_I);
    // accepted kinds; only address and pointer go busy
    wire go_pre = take && ok && MODE_I == `EAG_MODE_PRE_DEC;
    wire go_ptr = take && ok && MODE_I == `EAG_MODE_MEM_IND;
    wire go_rel = take && ok && (MODE_I == `EAG_MODE_PC_REL8 || MODE_I == `EAG_MODE_PC_REL16);
    wire go_addr = take && ok && has_ea;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (go_ptr) begin
                    nxt_state = ST_PTR;
                end else if (go_addr) begin
                    nxt_state = ST_ADDR;
                end
            end
            // stall holds address until bus takes it
            ST_ADDR: if (BUS_READY_I) nxt_state = ST_DONE;
            ST_PTR: if (PTR_VALID_I) nxt_state = ST_DONE;
            // done cycle lets the write-back pulse clear
            ST_DONE: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // ==========================================
    // registered outputs
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_ff <= ST_IDLE;
            mode_ff <= 4'h0;
            size_ff <= 2'h0;
            wreg_ff <= 3'h0;
            wdata_ff <= 32'h00000000;
            post_ff <= 1'b0;
            ADDR_VALID_O <= 1'b0;
            ADDR_O <= 16'h0000;
            ADDR_SIZE_O <= 2'h0;
            PTR_REQ_O <= 1'b0;
            PTR_ADDR_O <= 16'h0000;
            OPND_VALID_O <= 1'b0;
            OPND_O <= 32'h00000000;
            BIT_NUM_O <= 3'h0;
            BRANCH_VALID_O <= 1'b0;
            BRANCH_O <= 24'h000000;
            WB_VALID_O <= 1'b0;
            WB_REG_O <= 3'h0;
            WB_DATA_O <= 32'h00000000;
            ILLEGAL_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // busy mirrors state so a held start is refused
            BUSY_O <= (nxt_state != ST_IDLE);
            OPND_VALID_O <= 1'b0;
            BRANCH_VALID_O <= 1'b0;
            WB_VALID_O <= 1'b0;
            ILLEGAL_O <= 1'b0;
            if (take) begin
                mode_ff <= MODE_I;
                size_ff <= SIZE_I;
                wreg_ff <= RSEL_I[2:0];
                post_ff <= (MODE_I == `EAG_MODE_POST_INC);
                // sum kept at accept; a stall cannot change it
                wdata_ff <= (MODE_I == `EAG_MODE_POST_INC) ? inc_val : dec_val;
                // reject modes outside the class subset
                ILLEGAL_O <= ~ok;
                BIT_NUM_O <= (CLASS_I == `EAG_CLS_BIT) ? BIT_IMM_I : reg_val[2:0];
                if (go_addr) begin
                    ADDR_VALID_O <= 1'b1;
                    ADDR_O <= ea[`EAG_OUT_AW-1:0];
                    ADDR_SIZE_O <= SIZE_I;
                end
                if (go_pre) begin
                    WB_VALID_O <= 1'b1;
                    WB_REG_O <= RSEL_I[2:0];
                    WB_DATA_O <= dec_val;
                end
                if (go_ptr) begin
                    // zero-extended pointer address
                    // table shares the vector area
                    PTR_REQ_O <= 1'b1;
                    PTR_ADDR_O <= {8'h00, EXT_I[7:0]};
                end
                if (ok && MODE_I == `EAG_MODE_REG_DIRECT) begin
                    OPND_VALID_O <= 1'b1;
                    OPND_O <= reg_val;
                end
                if (ok && MODE_I == `EAG_MODE_IMM) begin
                    OPND_VALID_O <= 1'b1;
                    OPND_O <= (CLASS_I == `EAG_CLS_TRAP) ? {28'h0000000, TRAP_IMM_I, 2'h0} : imm_val;
                end
                if (go_rel) begin
                    BRANCH_VALID_O <= 1'b1;
                    BRANCH_O <= (MODE_I == `EAG_MODE_PC_REL8) ? rel8 : rel16;
                end
            end
            if (state_ff == ST_ADDR && BUS_READY_I) begin
                ADDR_VALID_O <= 1'b0;
                if (post_ff) begin
                    WB_VALID_O <= 1'b1;
                    WB_REG_O <= wreg_ff;
                    WB_DATA_O <= wdata_ff;
                end
            end
            if (state_ff == ST_PTR && PTR_VALID_I) begin
                PTR_REQ_O <= 1'b0;
                BRANCH_VALID_O <= 1'b1;
                BRANCH_O <= PTR_DATA_I[23:0];
            end
        end
    end
endmodule

`default_nettype wire

// [verif/eag_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eag_consts.vh"
// ==============================
// port checks
module eag_asserts (
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic START_I,
    input wire logic [2:0] CLASS_I,
    input wire logic [3:0] MODE_I,
    input wire logic [31:0] EXT_I,
    input wire logic BUS_READY_I,
    input wire logic ADDR_VALID_O,
    input wire logic [15:0] ADDR_O,
    input wire logic [1:0] ADDR_SIZE_O,
    input wire logic PTR_REQ_O,
    input wire logic [15:0] PTR_ADDR_O,
    input wire logic OPND_VALID_O,
    input wire logic BRANCH_VALID_O,
    input wire logic WB_VALID_O,
    input wire logic [31:0] WB_DATA_O,
    input wire logic ILLEGAL_O,
    input wire logic BUSY_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    wire logic take = START_I && !BUSY_O;
    wire logic [7:0] ext_lo = EXT_I[7:0];
    a_addr_hold: assert property (ADDR_VALID_O && !BUS_READY_I |=> ADDR_VALID_O && $stable(ADDR_O))
        else $error("address left early");
    a_addr_done: assert property (ADDR_VALID_O && BUS_READY_I |=> !ADDR_VALID_O ##1 !BUSY_O)
        else $error("access did not finish");
    a_wb_once: assert property (WB_VALID_O |=> !WB_VALID_O)
        else $error("write-back repeated");
    a_post_step: assert property (ADDR_VALID_O && BUS_READY_I ##1 WB_VALID_O
        |-> WB_DATA_O[15:0] == $past(ADDR_O) + (16'h1 << $past(ADDR_SIZE_O)))
        else $error("post step wrong");
    a_pre_addr: assert property ($rose(ADDR_VALID_O) && WB_VALID_O |-> WB_DATA_O[15:0] == ADDR_O)
        else $error("pre address not result");
    a_busy_refuse: assert property (BUSY_O && START_I |=> !OPND_VALID_O && !ILLEGAL_O)
        else $error("request taken while busy");
    a_req_answer: assert property (take |=> ADDR_VALID_O || PTR_REQ_O || OPND_VALID_O || BRANCH_VALID_O || ILLEGAL_O)
        else $error("no answer");
    a_abs8_fill: assert property (take && MODE_I == `EAG_MODE_ABS8 && CLASS_I == `EAG_CLS_TRANSFER
        |=> ADDR_O == {8'hFF, $past(ext_lo)})
        else $error("short absolute fill wrong");
    a_ptr_addr: assert property (take && MODE_I == `EAG_MODE_MEM_IND && CLASS_I == `EAG_CLS_JUMP
        |=> PTR_REQ_O && PTR_ADDR_O == {8'h00, $past(ext_lo)})
        else $error("pointer address wrong");
    c_post: cover property (ADDR_VALID_O && BUS_READY_I ##1 WB_VALID_O);
    c_refuse: cover property (BUSY_O && START_I);
    c_illegal: cover property (ILLEGAL_O);
    c_pre: cover property ($rose(ADDR_VALID_O) && WB_VALID_O);
    c_ptr: cover property (PTR_REQ_O ##1 !PTR_REQ_O && BRANCH_VALID_O);
endmodule
bind eag_top eag_asserts i_eag_asserts (.*);
`default_nettype wire

// [verif/eag_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==============================
// bus side, random stalls
module eag_bus_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic addr_valid_i,
    input wire logic ptr_req_i,
    output logic bus_ready_o,
    output logic ptr_valid_o,
    output logic [31:0] ptr_data_o
);
    logic [15:0] lfsr_ff;
    initial begin
        bus_ready_o = 1'b0;
        ptr_valid_o = 1'b0;
        ptr_data_o = 32'h0;
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lfsr_ff <= 16'hACE1;
            bus_ready_o <= 1'b0;
            ptr_valid_o <= 1'b0;
        end else begin
            lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
            bus_ready_o <= addr_valid_i && !bus_ready_o && lfsr_ff[0];
            ptr_valid_o <= ptr_req_i && !ptr_valid_o && lfsr_ff[1];
            ptr_data_o <= {lfsr_ff, ~lfsr_ff};
        end
    end
endmodule
`default_nettype wire

// [verif/tb_eag_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_eag_top;
    reg SYS_CLK_I = 1'b0, RESETN_I = 1'b0, START_I = 1'b0;
    reg [2:0] CLASS_I = 3'h0, BIT_IMM_I = 3'h0;
    reg [3:0] MODE_I = 4'h0, RSEL_I = 4'h0, m;
    reg [1:0] SIZE_I = 2'h0, TRAP_IMM_I = 2'h0;
    reg [31:0] EXT_I = 32'h0, seed = 32'h8E85, k;
    reg [23:0] PC_NEXT_I = 24'h0;
    reg [255:0] REGS_I = 256'h0;
    wire BUS_READY_I, PTR_VALID_I, ADDR_VALID_O, PTR_REQ_O, OPND_VALID_O, BRANCH_VALID_O, WB_VALID_O, ILLEGAL_O, BUSY_O;
    wire [31:0] PTR_DATA_I, OPND_O, WB_DATA_O;
    wire [15:0] ADDR_O, PTR_ADDR_O;
    wire [23:0] BRANCH_O;
    wire [2:0] BIT_NUM_O, WB_REG_O;
    wire [1:0] ADDR_SIZE_O;
    integer errors = 0, checks = 0;
    always #2 SYS_CLK_I = ~SYS_CLK_I;
    eag_top i_eag_top (.*);
    eag_bus_model i_eag_bus_model (.clk_i(SYS_CLK_I), .rst_n_i(RESETN_I), .addr_valid_i(ADDR_VALID_O),
        .ptr_req_i(PTR_REQ_O), .bus_ready_o(BUS_READY_I), .ptr_valid_o(PTR_VALID_I), .ptr_data_o(PTR_DATA_I));
    // ==============================
    // helpers
    function [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction
    function lg(input [2:0] c, input [3:0] m);
        case (c)
            3'h0: lg = m == 4'h0 || m == 4'h9;
            3'h1: lg = m <= 4'h9;
            3'h2: lg = m <= 4'h1 || (m >= 4'h6 && m <= 4'h8);
            3'h3: lg = m == 4'hA || m == 4'hB;
            3'h4: lg = m == 4'h1 || m == 4'h8 || m == 4'hC;
            3'h5, 3'h6: lg = m == 4'h9;
            default: lg = 1'b0;
        endcase
    endfunction
    function [31:0] ea(input [3:0] m, input [31:0] r);
        case (m)
            4'h2: ea = r + {{16{EXT_I[15]}}, EXT_I[15:0]};
            4'h3: ea = r + {8'h00, EXT_I[23:0]};
            4'h5: ea = r - (32'h1 << SIZE_I);
            4'h6: ea = {16'hFFFF, EXT_I[7:0]};
            4'h7: ea = {{16{EXT_I[15]}}, EXT_I[15:0]};
            4'h8: ea = {8'h00, EXT_I[23:0]};
            default: ea = r;
        endcase
    endfunction
    function [31:0] ov(input [2:0] c, input [3:0] m, input [31:0] r);
        if (c == 3'h6) ov = {28'h0, TRAP_IMM_I, 2'h0};
        else if (m == 4'h9) ov = EXT_I & (SIZE_I == 2'h0 ? 32'hFF : SIZE_I == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF);
        else if (SIZE_I == 2'h2) ov = r;
        else if (SIZE_I == 2'h1) ov = RSEL_I[3] ? r[31:16] : r[15:0];
        else ov = RSEL_I[3] ? r[7:0] : r[15:8];
    endfunction
    function sig(input [2:0] w);
        case (w)
            3'h0: sig = BUS_READY_I === 1'b1;
            3'h1: sig = PTR_VALID_I === 1'b1;
            3'h2: sig = BUSY_O === 1'b0;
            3'h3: sig = BRANCH_VALID_O === 1'b1;
            default: sig = (ADDR_VALID_O | PTR_REQ_O | OPND_VALID_O | BRANCH_VALID_O | ILLEGAL_O) === 1'b1;
        endcase
    endfunction
    task close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task tick;
        @(posedge SYS_CLK_I);
        #1;
    endtask
    // bounded wait; running out ends the run
    task wt(input [2:0] w, input integer lim);
        integer n;
        for (n = 0; n < lim && !sig(w); n = n + 1) tick;
        if (!sig(w)) begin
            errors = errors + 1;
            close_out;
        end
    endtask
    // start stays high through busy to probe refusal, and across idle ops
    task op(input [2:0] c, input [3:0] m, input [31:0] e);
        integer n;
        reg [31:0] r, x;
        CLASS_I = c;
        MODE_I = m;
        x = xs();
        SIZE_I = x[1:0] == 2'h3 ? 2'h2 : x[1:0];
        RSEL_I = x[5:2];
        BIT_IMM_I = x[8:6];
        TRAP_IMM_I = x[10:9];
        EXT_I = e & ~{31'h0, m == 4'hA || m == 4'hB};
        x = xs();
        PC_NEXT_I = {x[23:1], 1'b0};
        for (n = 0; n < 8; n = n + 1) REGS_I[32 * n +: 32] = xs() & {31'h7FFFFFFF, SIZE_I == 2'h0};
        r = REGS_I[32 * RSEL_I[2:0] +: 32];
        START_I = 1'b1;
        tick;
        wt(3'h4, 4);
        if (c == 3'h2 && lg(c, m)) chk(BIT_NUM_O, BIT_IMM_I, "bit_num");
        if (!lg(c, m)) chk(ILLEGAL_O, 32'h1, "illegal");
        else if (c == 3'h6 || m == 4'h0 || m == 4'h9) chk(OPND_O, ov(c, m, r), "opnd");
        else if (m >= 4'hA && m <= 4'hB) begin
            x = {8'h00, PC_NEXT_I} + (m == 4'hA ? {{24{EXT_I[7]}}, EXT_I[7:0]} : {{16{EXT_I[15]}}, EXT_I[15:0]});
            chk(BRANCH_O, x[23:0], "rel");
        end else if (m == 4'hC) begin
            chk(PTR_ADDR_O, {24'h0, EXT_I[7:0]}, "ptr_addr");
            wt(3'h1, 40);
            x = PTR_DATA_I;
            START_I = 1'b0;
            tick;
            wt(3'h3, 3);
            chk(BRANCH_O, x[23:0], "mem_ind");
        end else begin
            x = ea(m, r);
            chk(ADDR_O, x[15:0], "addr");
            chk(ADDR_SIZE_O, SIZE_I, "size");
            if (m == 4'h5) chk(WB_DATA_O & {32{WB_VALID_O}}, x, "pre_wb");
            if (m == 4'h5) chk(WB_REG_O, RSEL_I[2:0], "pre_reg");
            wt(3'h0, 40);
            tick;
            START_I = 1'b0;
            if (m == 4'h4) chk(WB_DATA_O & {32{WB_VALID_O}}, r + (32'h1 << SIZE_I), "post_wb");
            if (m == 4'h4) chk(WB_REG_O, RSEL_I[2:0], "wb_reg");
        end
        wt(3'h2, 4);
    endtask
    initial begin
        repeat (8) @(posedge SYS_CLK_I);
        #1 RESETN_I = 1'b1;
        op(3'h1, 4'h2, 32'h8000);
        op(3'h1, 4'h3, 32'hFF800001);
        op(3'h4, 4'h8, 32'h00ABCD12);
        op(3'h4, 4'h1, 32'h0);
        op(3'h5, 4'h9, 32'h1234);
        op(3'h6, 4'h0, 32'h0);
        op(3'h2, 4'h6, 32'h5A);
        op(3'h1, 4'h6, 32'h0);
        op(3'h1, 4'h7, 32'h8001);
        op(3'h0, 4'h1, 32'h0);
        op(3'h1, 4'hC, 32'h0);
        op(3'h6, 4'h9, 32'h0);
        op(3'h3, 4'hA, 32'h80);
        op(3'h4, 4'hC, 32'hFF);
        repeat (300) begin
            k = xs();
            m = k[3:0] % 4'hD;
            op(m == 4'hC ? 3'h4 : {1'b0, k[5:4]}, m, xs());
        end
        CLASS_I = 3'h1;
        MODE_I = 4'h2;
        START_I = 1'b1;
        tick;
        RESETN_I = 1'b0;
        START_I = 1'b0;
        tick;
        chk({ADDR_VALID_O, BUSY_O, WB_VALID_O}, 32'h0, "reset");
        RESETN_I = 1'b1;
        op(3'h1, 4'h5, 32'h0);
        close_out;
    end
endmodule
`default_nettype wire
